// >>> design/ptc_core.sv
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - The counter counts up, 16 or 10 bits wide, on each selected tick.
// - Comparators A and P match when the counter equals their values.
// - Software cannot load the counter; only a run enable rise zeroes it.
// - Overflow or the selected match clears the counter and flags an irq.
// - Counter reads as a byte pair; compare A and period are r/w pairs.
// - Only the first wide instance has compare B and a third control reg.
// - Pause bit set holds the count; clearing it resumes from there.
// - Clock select picks sys/2, sys, high/16, high/64, sub or pin edges.
// - Run enable lets it count, holds on 0, and zeroes on a 0-to-1 change.
// - A run enable rise in output modes sets the pin to its initial level.
// - Control 0 bits 2 to 0 ignore writes and read zero.
// - Narrow instances keep only bits 9 and 8 in their high bytes.
// - Low bytes move through a buffer only on the high byte access.
// - Two mode bits pick compare output, capture, PWM or timer mode.
// - Clear source 1 uses match A, else match P, or overflow if P is zero.
module ptc_core #(
   parameter int  CNT_W    = 16,
   parameter bit  HAS_CMPB = 1'b1
) (
   input  wire logic        mclk_in,
   input  wire logic        reset_n_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        fh_tick_in,
   input  wire logic        fsub_tick_in,
   input  wire logic        ext_clock_pin_in,
   output logic             timer_out,
   output logic             irq_out
);
   import ptc_pkg::*;

   function automatic logic [7:0] hi_byte(input logic [CNT_W-1:0] v);
      logic [15:0] w;
      w = 16'h0000;
      w[CNT_W-1:0] = v;
      return w[15:8];
   endfunction : hi_byte

   ////////////////////////////////////////////////////////////////////////
   logic rst_m_q, rst_n_q;
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end
   default clocking chk_cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_q);

   ////////////////////////////////////////////////////////////////////////
   logic [7:0]       ctrl0_q, ctrl1_q, ctrl2_q, buf_q, st_q, msk_q;
   logic [CNT_W-1:0] cnt_q, cmpa_q, cmpb_q, per_q;
   logic             acc, wr, rd;
   logic [7:0]       wb;
   assign acc = psel_in && penable_in;
   assign wr  = acc && pwrite_in;
   // Read strobe at setup, same edge as read data, so pairs stay coherent
   assign rd  = psel_in && !penable_in && !pwrite_in;
   assign wb  = pwdata_in[7:0];

   logic run, run_rise, pause;
   ptc_mode_t mode;
   ptc_clk_t  cksel;
   assign run   = ctrl0_q[RUN_BIT];
   assign pause = ctrl0_q[PAUSE_BIT];
   assign mode  = ptc_mode_t'(ctrl1_q[MODE_HI:MODE_LO]);
   assign cksel = ptc_clk_t'(ctrl0_q[CKSEL_HI:CKSEL_LO]);
   // Rise detected on the write itself
   assign run_rise = wr && (paddr_in == ADDR_CTRL0) && wb[RUN_BIT] && !run;

   ////////////////////////////////////////////////////////////////////////
   // All zero at reset
   // Control 0 low bits never stored
   always_ff @(posedge mclk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ctrl0_q <= RESET_BYTE;
         ctrl1_q <= RESET_BYTE;
         ctrl2_q <= RESET_BYTE;
      end else if (wr) begin
         case (paddr_in)
            ADDR_CTRL0: ctrl0_q <= wb & CTRL0_MASK;
            ADDR_CTRL1: ctrl1_q <= wb;
            ADDR_CTRL2: ctrl2_q <= HAS_CMPB ? (wb & CTRL2_MASK) : RESET_BYTE;
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         buf_q <= RESET_BYTE;
      end else if (wr) begin
         case (paddr_in)
            ADDR_CMPA_LO, ADDR_PER_LO: buf_q <= wb;
            ADDR_CMPB_LO: if (HAS_CMPB) buf_q <= wb;
            default: ;
         endcase
      end else if (rd) begin
         case (paddr_in)
            ADDR_CNT_HI:  buf_q <= cnt_q[7:0];
            ADDR_CMPA_HI: buf_q <= cmpa_q[7:0];
            ADDR_CMPB_HI: if (HAS_CMPB) buf_q <= cmpb_q[7:0];
            ADDR_PER_HI:  buf_q <= per_q[7:0];
            default: ;
         endcase
      end
   end

   // Value pairs load whole on the high byte write
   // High byte truncated to the counter width
   always_ff @(posedge mclk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cmpa_q <= '0;
         cmpb_q <= '0;
         per_q  <= '0;
      end else if (wr) begin
         case (paddr_in)
            ADDR_CMPA_HI: cmpa_q <= CNT_W'({wb, buf_q});
            ADDR_CMPB_HI: if (HAS_CMPB) cmpb_q <= CNT_W'({wb, buf_q});
            ADDR_PER_HI:  per_q  <= CNT_W'({wb, buf_q});
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin through three flops; an edge counts once stages 2 and 3 agree
   logic [2:0] pin_q;
   logic       pin_lvl_q;
   always_ff @(posedge mclk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pin_q     <= 3'b000;
         pin_lvl_q <= 1'b0;
      end else begin
         pin_q <= {pin_q[1:0], ext_clock_pin_in};
         if (pin_q[2] == pin_q[1]) pin_lvl_q <= pin_q[2];
      end
   end
   logic pin_agree;
   assign pin_agree = (pin_q[2] == pin_q[1]);

   // Prescalers for the system and high clock ratios
   logic       sys_half_q;
   logic [5:0] hdiv_q;
   always_ff @(posedge mclk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sys_half_q <= 1'b0;
         hdiv_q     <= 6'h00;
      end else begin
         sys_half_q <= ~sys_half_q;
         if (fh_tick_in) hdiv_q <= hdiv_q + 6'h01;
      end
   end

   logic tick;
   always_comb begin
      case (cksel)
         CK_SYS2: tick = sys_half_q;
         CK_SYS:  tick = 1'b1;
         CK_H16:  tick = fh_tick_in && (hdiv_q[3:0] == 4'(HDIV16 - 1));
         CK_H64:  tick = fh_tick_in && (hdiv_q == 6'(HDIV64 - 1));
         CK_SUB0, CK_SUB1: tick = fsub_tick_in;
         CK_PINR: tick = pin_agree && pin_q[2] && !pin_lvl_q;
         CK_PINF: tick = pin_agree && !pin_q[2] && pin_lvl_q;
         default: tick = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Comparators over all bits
   logic match_a, match_p, ovf, clr, adv;
   assign match_a = (cnt_q == cmpa_q);
   assign match_p = (cnt_q == per_q);
   assign adv = run && !pause && tick;
   assign ovf = adv && (cnt_q == {CNT_W{1'b1}});
   always_comb begin
      if (ctrl1_q[CLRSEL_BIT]) clr = adv && match_a;
      else if (per_q == '0)    clr = ovf;
      else                     clr = adv && match_p;
   end

   // Only the run rise zeroes it from software
   always_ff @(posedge mclk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cnt_q <= '0;
      end else if (run_rise || clr) begin
         cnt_q <= '0;
      end else if (adv) begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output behaviour per mode
   // Run rise restores the initial level in compare and PWM modes
   logic out_q, pwm_act;
   assign pwm_act = (cnt_q < cmpa_q);
   always_ff @(posedge mclk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         out_q <= 1'b0;
      end else if (run_rise && mode != MODE_CAP && mode != MODE_TMR) begin
         out_q <= ctrl1_q[OCTL_BIT];
      end else if (adv) begin
         case (mode)
            MODE_CMP: if (match_a) begin
               case (ctrl1_q[PINF_HI:PINF_LO])
                  2'b01: out_q <= 1'b0;
                  2'b10: out_q <= 1'b1;
                  2'b11: out_q <= ~out_q;
                  default: ;
               endcase
            end
            MODE_PWM: begin
               case (ctrl1_q[PINF_HI:PINF_LO])
                  2'b00: out_q <= ~ctrl1_q[OCTL_BIT];
                  2'b01: out_q <= ctrl1_q[OCTL_BIT];
                  default: out_q <= pwm_act ~^ ctrl1_q[OCTL_BIT];
               endcase
            end
            default: ;
         endcase
      end
   end
   always_ff @(posedge mclk_in or negedge rst_n_q) begin
      if (!rst_n_q) timer_out <= 1'b0;
      else          timer_out <= out_q ^ ctrl1_q[POL_BIT];
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky events, set beats write-one-clear
   logic [7:0] ev;
   always_comb begin
      ev = 8'h00;
      ev[IRQ_A]   = adv && match_a;
      ev[IRQ_P]   = adv && match_p;
      ev[IRQ_OVF] = ovf;
      ev[IRQ_W]   = clr;
   end
   always_ff @(posedge mclk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         st_q  <= RESET_BYTE;
         msk_q <= RESET_BYTE;
         irq_out <= 1'b0;
      end else begin
         if (wr && paddr_in == ADDR_IRQ_ST) st_q <= (st_q & ~wb) | ev;
         else st_q <= st_q | ev;
         if (wr && paddr_in == ADDR_IRQ_MSK) msk_q <= wb;
         irq_out <= |(st_q & msk_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB: zero wait states, error on unmapped address
   logic       mapped;
   logic [7:0] rbyte;
   always_comb begin
      mapped = 1'b1;
      rbyte  = 8'h00;
      case (paddr_in)
         ADDR_CTRL0:   rbyte = ctrl0_q;
         ADDR_CTRL1:   rbyte = ctrl1_q;
         // Third control and pair B absent on small instances
         ADDR_CTRL2: begin
            rbyte  = ctrl2_q;
            mapped = HAS_CMPB;
         end
         ADDR_CNT_LO, ADDR_CMPA_LO, ADDR_PER_LO: rbyte = buf_q;
         ADDR_CMPB_LO: begin
            rbyte  = buf_q;
            mapped = HAS_CMPB;
         end
         ADDR_CNT_HI:  rbyte = hi_byte(cnt_q);
         ADDR_CMPA_HI: rbyte = hi_byte(cmpa_q);
         ADDR_CMPB_HI: begin
            rbyte  = hi_byte(cmpb_q);
            mapped = HAS_CMPB;
         end
         ADDR_PER_HI:  rbyte = hi_byte(per_q);
         ADDR_IRQ_ST:  rbyte = st_q;
         ADDR_IRQ_MSK: rbyte = msk_q;
         default:      mapped = 1'b0;
      endcase
   end
   always_ff @(posedge mclk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         prdata_out  <= 32'h0000_0000;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out  <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && !mapped;
         if (psel_in && !penable_in && !pwrite_in)
            prdata_out <= {24'h00_0000, rbyte};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Run rise in compare mode, then the pin two edges later
   sequence s_rise_cmp;
      run_rise && mode == MODE_CMP;
   endsequence
   sequence s_init_seen;
      ##1 timer_out == ($past(ctrl1_q[OCTL_BIT], 2) ^ ctrl1_q[POL_BIT]);
   endsequence

   chk_stop_holds: assert property (
      !run && !run_rise |=> $stable(cnt_q))
      else $error("count moved while off");
   chk_pause_holds: assert property (
      pause && !run_rise |=> $stable(cnt_q))
      else $error("count moved in pause");
   chk_run_zero: assert property (
      run_rise |=> cnt_q == '0)
      else $error("run rise did not zero");
   chk_no_load: assert property (
      wr && !run_rise && !adv |=> $stable(cnt_q))
      else $error("write changed count");
   chk_clear_match: assert property (
      clr |=> cnt_q == '0 && st_q[IRQ_W])
      else $error("clear missed");
   chk_irq_level: assert property (
      (|(st_q & msk_q)) |=> irq_out)
      else $error("irq not raised");
   chk_a_clear: assert property (
      adv && match_a && ctrl1_q[CLRSEL_BIT] |=> cnt_q == '0)
      else $error("match A did not clear");
   chk_p_clear: assert property (
      adv && match_p && !ctrl1_q[CLRSEL_BIT] && per_q != '0 |=> cnt_q == '0)
      else $error("period match did not clear");
   // Overflow clears with a zero period
   chk_ovf_clear: assert property (
      ovf && !ctrl1_q[CLRSEL_BIT] && per_q == '0 |=> st_q[IRQ_W])
      else $error("overflow clear not flagged");
   chk_count_up: assert property (
      adv && !clr && !run_rise |=> cnt_q == $past(cnt_q) + CNT_W'(1))
      else $error("bad increment");
   chk_init_level: assert property (
      s_rise_cmp |=> s_init_seen)
      else $error("initial level wrong");
   chk_ctrl0_low: assert property (
      ctrl0_q[2:0] == 3'b000)
      else $error("ctrl0 low bits set");
   // Unused high byte bits read zero
   chk_hi_unused: assert property (
      rd && paddr_in == ADDR_CNT_HI |=> prdata_out[31:CNT_W-8] == '0)
      else $error("unused high bits set");
   chk_buf_latch: assert property (
      rd && paddr_in == ADDR_PER_HI |=> buf_q == per_q[7:0])
      else $error("buffer not latched");
   // Absent pair answers with an error
   chk_no_cmpb: assert property (
      !HAS_CMPB && rd && paddr_in == ADDR_CMPB_HI |=> pslverr_out)
      else $error("missing compare B not refused");
endmodule : ptc_core
`default_nettype wire

// >>> pkg/ptc_pkg.sv
package ptc_pkg;
   // Byte registers, one per aligned APB word
   localparam logic [7:0] ADDR_CTRL0   = 8'h00;
   localparam logic [7:0] ADDR_CTRL1   = 8'h04;
   localparam logic [7:0] ADDR_CTRL2   = 8'h08;
   localparam logic [7:0] ADDR_CNT_LO  = 8'h0C;
   localparam logic [7:0] ADDR_CNT_HI  = 8'h10;
   localparam logic [7:0] ADDR_CMPA_LO = 8'h14;
   localparam logic [7:0] ADDR_CMPA_HI = 8'h18;
   localparam logic [7:0] ADDR_CMPB_LO = 8'h1C;
   localparam logic [7:0] ADDR_CMPB_HI = 8'h20;
   localparam logic [7:0] ADDR_PER_LO  = 8'h24;
   localparam logic [7:0] ADDR_PER_HI  = 8'h28;
   localparam logic [7:0] ADDR_IRQ_ST  = 8'h2C;
   localparam logic [7:0] ADDR_IRQ_MSK = 8'h30;
   // Control 0 fields
   localparam int PAUSE_BIT  = 7;
   localparam int CKSEL_HI   = 6;
   localparam int CKSEL_LO   = 4;
   localparam int RUN_BIT    = 3;
   localparam logic [7:0] CTRL0_MASK = 8'hF8;
   // Control 1 fields
   localparam int MODE_HI    = 7;
   localparam int MODE_LO    = 6;
   localparam int PINF_HI    = 5;
   localparam int PINF_LO    = 4;
   localparam int OCTL_BIT   = 3;
   localparam int POL_BIT    = 2;
   localparam int CLRSEL_BIT = 0;
   localparam logic [7:0] CTRL2_MASK = 8'h07;
   // Interrupt status bits
   localparam int IRQ_A   = 0;
   localparam int IRQ_P   = 1;
   localparam int IRQ_OVF = 2;
   localparam int IRQ_W   = 3;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   typedef enum logic [2:0] {
      CK_SYS2 = 3'b000, CK_SYS = 3'b001, CK_H16 = 3'b010,
      CK_H64 = 3'b011, CK_SUB0 = 3'b100, CK_SUB1 = 3'b101,
      CK_PINR = 3'b110, CK_PINF = 3'b111
   } ptc_clk_t;
   typedef enum logic [1:0] {
      MODE_CMP = 2'b00, MODE_CAP = 2'b01, MODE_PWM = 2'b10,
      MODE_TMR = 2'b11
   } ptc_mode_t;
   localparam int HDIV16 = 16;
   localparam int HDIV64 = 64;
endpackage : ptc_pkg

// >>> tb/ptc_pin_drv.sv
`timescale 1ns/100ps
`default_nettype none
module ptc_pin_drv (
   input  wire logic clk_in,
   output logic      pin_out
);
   initial pin_out = 1'b0;
   ////////////////////////////////////////////////////////////////////////
   // Level held 8 cycles so the pin synchroniser sees each edge
   // pin edge source
   task automatic drive(input logic v);
      @(posedge clk_in);
      pin_out <= v;
      repeat (8) @(posedge clk_in);
   endtask : drive
endmodule : ptc_pin_drv
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import ptc_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0;
   logic        pwr = 1'b0, fh = 1'b0, fsub = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic        pready, pslverr, pin, tout, irq, err;
   int          num_errors = 0, checks_done = 0, cnt, clv, va;
   logic [7:0]  ra [10] = '{8'h00, 8'h04, 8'h10, 8'h0C, 8'h18, 8'h14,
                            8'h28, 8'h24, 8'h2C, 8'h30};
   always #4 clk = ~clk;
   always @(posedge clk) begin
      fh <= 1'($urandom);
      fsub <= 1'($urandom);
   end
   ptc_core #(.CNT_W(10), .HAS_CMPB(1'b0)) u_ptc_core (
      .mclk_in(clk), .reset_n_in(rst_n), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .fh_tick_in(fh), .fsub_tick_in(fsub),
      .ext_clock_pin_in(pin), .timer_out(tout), .irq_out(irq));
   ptc_pin_drv u_ptc_pin_drv (.clk_in(clk), .pin_out(pin));
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (num_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      apb(1'b0, a, 8'h00);
      chk(nm, e, rd);
   endtask : rdc
   // Pair access order
   // Low byte first on write, high byte first on read
   task automatic wpair(input logic [7:0] lo, input int v);
      wr(lo, 8'(v));
      wr(lo + 8'h04, 8'(v >> 8));
   endtask : wpair
   task automatic rpair(input string nm, input logic [7:0] lo, input int v);
      rdc(nm, lo + 8'h04, 32'(v >> 8));
      rdc(nm, lo, 32'(v & 255));
   endtask : rpair
   // Model tick: clear on the selected match, else wrap at 10 bits
   task automatic tk(input logic v, input int n);
      u_ptc_pin_drv.drive(v);
      if (n > 0) begin
         cnt = (cnt == clv) ? 0 : (cnt + 1) % 1024;
      end
   endtask : tk
   task automatic st_bit(input string nm, input int b);
      apb(1'b0, ADDR_IRQ_ST, 8'h00);
      chk(nm, 32'h0000_0001, 32'(rd[b]));
   endtask : st_bit
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #(8 * 30000);
      num_errors++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'h56b5));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      foreach (ra[i]) rdc("reset", ra[i], 32'h0000_0000);
      wr(ADDR_CTRL0, 8'hFF);
      rdc("ctrl0", ADDR_CTRL0, 32'h0000_00F8);
      wr(ADDR_CTRL0, 8'h00);
      for (int m = 0; m < 4; m++) begin
         va = (m << 6) | ($urandom % 64);
         wr(ADDR_CTRL1, 8'(va));
         rdc("ctrl1", ADDR_CTRL1, 32'(va));
      end
      wpair(ADDR_CMPA_LO, 16'hFF5A);
      rpair("cmpa", ADDR_CMPA_LO, 16'h035A);
      clv = $urandom % 1024;
      wpair(ADDR_PER_LO, clv);
      rpair("period", ADDR_PER_LO, clv);
      if (clv == 0) clv = 1023;
      apb(1'b1, 8'h34, 8'hFF);
      chk("unmapped", 32'h0000_0001, 32'(err));
      apb(1'b0, ADDR_CMPB_HI, 8'h00);
      chk("cmpb", 32'h0000_0001, 32'(err));
      apb(1'b0, ADDR_CTRL2, 8'h00);
      chk("ctrl2", 32'h0000_0001, 32'(err));
      wr(ADDR_CTRL1, 8'h00);
      wr(ADDR_CTRL0, 8'h68);
      cnt = 0;
      tk(1'b1, 1);
      tk(1'b0, 0);
      rpair("rise", ADDR_CNT_LO, cnt);
      wr(ADDR_CTRL0, 8'h78);
      tk(1'b1, 0);
      tk(1'b0, 1);
      rpair("fall", ADDR_CNT_LO, cnt);
      wr(ADDR_CTRL0, 8'hF8);
      tk(1'b1, 0);
      tk(1'b0, 0);
      rpair("pause", ADDR_CNT_LO, cnt);
      wr(ADDR_CTRL0, 8'h78);
      tk(1'b1, 0);
      tk(1'b0, 1);
      rpair("resume", ADDR_CNT_LO, cnt);
      wr(ADDR_CTRL0, 8'h70);
      tk(1'b1, 0);
      tk(1'b0, 0);
      rpair("off", ADDR_CNT_LO, cnt);
      wr(ADDR_CTRL0, 8'h78);
      cnt = 0;
      rpair("on", ADDR_CNT_LO, cnt);
      for (int s = 0; s < 2; s++) begin
         clv = 2 + $urandom % 4;
         wpair(s ? ADDR_CMPA_LO : ADDR_PER_LO, clv);
         wr(ADDR_CTRL1, 8'(s));
         wr(ADDR_CTRL0, 8'h70);
         wr(ADDR_CTRL0, 8'h78);
         wr(ADDR_IRQ_ST, 8'hFF);
         cnt = 0;
         // Falling pin edges advance the count here
         repeat (clv + 1) begin
            tk(1'b1, 0);
            tk(1'b0, 1);
         end
         rpair("match", ADDR_CNT_LO, cnt);
         st_bit("match_st", s ? IRQ_A : IRQ_P);
      end
      wr(ADDR_IRQ_MSK, 8'h00);
      repeat (2) @(posedge clk);
      chk("irq_masked", 32'h0000_0000, 32'(irq));
      wr(ADDR_IRQ_MSK, 8'hFF);
      rdc("mask", ADDR_IRQ_MSK, 32'h0000_00FF);
      chk("irq_mask", 32'h0000_0001, 32'(irq));
      wr(ADDR_CTRL0, 8'h00);
      wr(ADDR_IRQ_ST, 8'hFF);
      rdc("st_clr", ADDR_IRQ_ST, 32'h0000_0000);
      chk("irq_clr", 32'h0000_0000, 32'(irq));
      wpair(ADDR_PER_LO, 0);
      wr(ADDR_CTRL1, 8'h00);
      wr(ADDR_CTRL0, 8'h18);
      repeat (1100) @(posedge clk);
      wr(ADDR_CTRL0, 8'h10);
      st_bit("overflow", IRQ_OVF);
      for (int oc = 1; oc >= 0; oc--) begin
         wr(ADDR_CTRL0, 8'h00);
         wr(ADDR_CTRL1, 8'(oc << OCTL_BIT));
         wr(ADDR_CTRL0, 8'h88);
         repeat (3) @(posedge clk);
         chk("timer_out", 32'(oc), 32'(tout));
      end
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
